//--- core/cdf_filter_select.sv
// Command damping filter bank with selection, clamp and deferred update
//
// Contract
// RL1: Damp only in position control mode.
// RL2: Four frequencies, at most two active.
// RL3: Remove vibration components from position command.
// RL4: Select zero allows two filters together.
// RL5: Host never writes select codes one, two.
// RL6: Select three, positive: filters one, three.
// RL7: Select three, negative: filters two, four.
// RL8: Frequency range 0 to 2000, 0.1 Hz.
// RL9: Frequency 0 to 9 disables filter.
// RL10: Filter setting clamped to min(f, 2000-f).
// RL11: Host normally leaves filter setting zero.
// RL12: Depth acts on first filter only.
// RL13: Depth zero deepest, larger values shallower.
// RL14: Apply settings on command start, in-position.
// RL15: Start during computation delay postpones apply.
// RL16: Disabled filter passes command unchanged, no delay.
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module cdf_filter_select
    import cdf_pkg::*;
#(
    parameter int CMD_W = 16
)(
    input  wire logic             ref_clk_i,
    input  wire logic             reset_i,
    input  wire logic [5:0]       avs_address_i,
    input  wire logic             avs_read_i,
    input  wire logic             avs_write_i,
    input  wire logic [31:0]      avs_writedata_i,
    output logic      [31:0]      avs_readdata_o,
    output logic                  avs_waitrequest_o,
    input  wire logic             pos_mode_i,
    input  wire logic             inpos_i,
    input  wire logic             cmd_valid_i,
    input  wire logic [CMD_W-1:0] cmd_i,
    output logic                  cmd_valid_o,
    output logic      [CMD_W-1:0] cmd_o
);

    if (CMD_W < 2 || CMD_W > 18)
    begin : g_bad_width
        $error("CMD_W must lie in 2..18");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Functions
    function automatic logic [CDF_FILT_W-1:0] clamp_filt(input logic [CDF_FILT_W-1:0] filt,
                                                         input logic [CDF_FREQ_W-1:0] freq);
        logic [CDF_FREQ_W-1:0] lim;
        lim = (freq < CDF_FREQ_MAX - freq) ? freq : CDF_FREQ_MAX - freq;
        if ({1'b0, filt} > lim)
            clamp_filt = lim[CDF_FILT_W-1:0];
        else
            clamp_filt = filt;
    endfunction

    // Keeps the lowest two set bits of a mask
    function automatic logic [3:0] first_two(input logic [3:0] m);
        logic [3:0] a;
        a = m & (~m + 4'h1);
        first_two = a | ((m & ~a) & (~(m & ~a) + 4'h1));
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register bus
    logic                  wait_q;
    logic [31:0]           rdata_q;
    logic [CDF_SEL_W-1:0]  sel_sh_q;
    logic [CDF_FILT_W-1:0] depth_sh_q;
    logic [CDF_FREQ_W-1:0] freq_sh_q [CDF_NFILT];
    logic [CDF_FILT_W-1:0] filt_sh_q [CDF_NFILT];
    logic [CDF_SEL_W-1:0]  sel_act_q;
    logic [CDF_FILT_W-1:0] depth_act_q;
    logic [CDF_FREQ_W-1:0] freq_act_q [CDF_NFILT];
    logic [CDF_FILT_W-1:0] filt_act_q [CDF_NFILT];
    cdf_state_t            state_q;
    logic [7:0]            calc_cnt_q;
    logic                  dir_neg_q;
    logic                  prev_zero_q;
    logic [3:0]            en_mask;
    logic                  bus_req;
    logic                  wr_ok;
    logic                  switch_now;
    logic                  apply;

    assign bus_req = avs_read_i | avs_write_i;
    assign wr_ok   = avs_write_i & ~wait_q;

    // Wait one cycle, then answer; access completes on the low edge
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
            wait_q <= 1'b1;
        else
            wait_q <= !(bus_req && wait_q);
    end

    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
            rdata_q <= 32'h0000_0000;
        else if (avs_read_i && wait_q)
        begin
            rdata_q <= 32'h0000_0000;
            if (avs_address_i == CDF_OFS_SEL)
                rdata_q[CDF_SEL_W-1:0] <= sel_sh_q;
            else if (avs_address_i == CDF_OFS_DEPTH)
                rdata_q[CDF_FILT_W-1:0] <= depth_sh_q;
            else if (avs_address_i == CDF_OFS_STATUS)
            begin
                rdata_q[CDF_SEL_W-1:0]          <= sel_act_q;
                rdata_q[CDF_ST_EN+3:CDF_ST_EN]  <= en_mask;
                rdata_q[CDF_ST_DIR]             <= dir_neg_q;
                rdata_q[CDF_ST_FSM+2:CDF_ST_FSM] <= state_q;
            end
            else
            begin
                for (int i = 0; i < CDF_NFILT; i++)
                begin
                    if (avs_address_i == CDF_OFS_FREQ0 + 6'(4 * i))
                        rdata_q[CDF_FREQ_W-1:0] <= freq_sh_q[i];
                    if (avs_address_i == CDF_OFS_FILT0 + 6'(4 * i))
                        rdata_q[CDF_FILT_W-1:0] <= filt_sh_q[i];
                end
            end
        end
    end

    // Depth, frequency and filter writes beyond the legal range are held at the top of the range; select keeps its low two bits
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            sel_sh_q   <= CDF_SEL_RST;
            depth_sh_q <= CDF_DEPTH_RST;
            for (int i = 0; i < CDF_NFILT; i++)
            begin
                freq_sh_q[i] <= CDF_FREQ_RST;
                filt_sh_q[i] <= CDF_FILT_RST;
            end
        end
        else if (wr_ok)
        begin
            if (avs_address_i == CDF_OFS_SEL)
                sel_sh_q <= avs_writedata_i[CDF_SEL_W-1:0];
            if (avs_address_i == CDF_OFS_DEPTH)
                depth_sh_q <= (avs_writedata_i > 32'(CDF_DEPTH_MAX)) ? CDF_DEPTH_MAX
                              : avs_writedata_i[CDF_FILT_W-1:0];
            for (int i = 0; i < CDF_NFILT; i++)
            begin
                if (avs_address_i == CDF_OFS_FREQ0 + 6'(4 * i))
                    freq_sh_q[i] <= (avs_writedata_i > 32'(CDF_FREQ_MAX)) ? CDF_FREQ_MAX
                                    : avs_writedata_i[CDF_FREQ_W-1:0];  // see RL8
                if (avs_address_i == CDF_OFS_FILT0 + 6'(4 * i))
                    filt_sh_q[i] <= (avs_writedata_i > 32'(CDF_FILT_MAX)) ? CDF_FILT_MAX
                                    : avs_writedata_i[CDF_FILT_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Deferred application of new settings
    assign switch_now = cmd_valid_i && (cmd_i != '0) && prev_zero_q
                        && inpos_i && pos_mode_i;  // see RL14
    assign apply      = (state_q == CDF_ST_PEND) && switch_now;

    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
            prev_zero_q <= 1'b1;
        else if (cmd_valid_i)
            prev_zero_q <= (cmd_i == '0);
    end

    // A start seen while still computing is skipped, not queued
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_q    <= CDF_ST_IDLE;
            calc_cnt_q <= 8'h00;
        end
        else if (wr_ok)
        begin
            state_q    <= CDF_ST_CALC;
            calc_cnt_q <= 8'(CDF_CALC_CYC - 1);
        end
        else
        begin
            unique case (state_q)
                CDF_ST_IDLE: state_q <= CDF_ST_IDLE;
                CDF_ST_CALC:
                begin
                    if (calc_cnt_q == 8'h00)
                        state_q <= CDF_ST_PEND;
                    else
                        calc_cnt_q <= calc_cnt_q - 8'h01;  // see RL15
                end
                CDF_ST_PEND:
                begin
                    if (apply)
                        state_q <= CDF_ST_IDLE;
                end
                default: state_q <= CDF_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            sel_act_q   <= CDF_SEL_RST;
            depth_act_q <= CDF_DEPTH_RST;
            for (int i = 0; i < CDF_NFILT; i++)
            begin
                freq_act_q[i] <= CDF_FREQ_RST;
                filt_act_q[i] <= CDF_FILT_RST;
            end
        end
        else if (apply)
        begin
            sel_act_q   <= sel_sh_q;
            depth_act_q <= depth_sh_q;
            for (int i = 0; i < CDF_NFILT; i++)
            begin
                freq_act_q[i] <= freq_sh_q[i];
                filt_act_q[i] <= clamp_filt(filt_sh_q[i], freq_sh_q[i]);  // see RL10
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Filter selection
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
            dir_neg_q <= 1'b0;
        else if (cmd_valid_i && cmd_i != '0)
            dir_neg_q <= cmd_i[CMD_W-1];
    end

    logic [3:0] valid_mask;
    logic       dir_neg;

    // Zero command keeps the last direction so filters do not chatter
    assign dir_neg = (cmd_valid_i && cmd_i != '0) ? cmd_i[CMD_W-1] : dir_neg_q;

    always_comb
    begin
        for (int i = 0; i < CDF_NFILT; i++)
            valid_mask[i] = freq_act_q[i] > CDF_FREQ_INVLD;  // see RL9
        if (sel_act_q == CDF_SEL_DIR)
            en_mask = valid_mask & (dir_neg ? 4'hA : 4'h5);  // see RL6 RL7
        else
            en_mask = first_two(valid_mask);  // see RL2 RL4
    end

    ////////////////////////////////////////////////////////////////////////////
    // Filter chain
    logic signed [31:0] y_q      [CDF_NFILT];
    logic signed [31:0] stage_in [CDF_NFILT];
    logic signed [31:0] stage_lp [CDF_NFILT];
    logic signed [31:0] chain_out;

    // One low-pass stage per filter; disabled ones forward their input
    // All operands signed, so a falling command shifts arithmetically
    always_comb
    begin
        logic signed [31:0] v;
        logic signed [31:0] lp;
        logic signed [31:0] k;
        v  = 32'(signed'(cmd_i));
        lp = 32'sd0;
        k  = 32'sd0;
        for (int i = 0; i < CDF_NFILT; i++)
        begin
            stage_in[i] = v;
            k           = 32'(freq_act_q[i]) + 32'(filt_act_q[i]);
            stage_lp[i] = y_q[i] + (((v - y_q[i]) * k) >>> CDF_COEF_SHIFT);  // see RL3
            lp          = stage_lp[i];
            if (i == 0)
                lp = lp + (((v - lp) * 32'(signed'({1'b0, depth_act_q})))
                     >>> CDF_DEPTH_SHIFT);  // see RL12 RL13
            if (en_mask[i])
                v = lp;
        end
        chain_out = v;  // see RL16
    end

    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
            for (int i = 0; i < CDF_NFILT; i++)
                y_q[i] <= 32'sd0;
        else if (cmd_valid_i)
            for (int i = 0; i < CDF_NFILT; i++)
                y_q[i] <= (en_mask[i] && pos_mode_i) ? stage_lp[i] : stage_in[i];
    end

    // Output stage; chain output is not saturated, gain is at most unity
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            cmd_valid_o <= 1'b0;
            cmd_o       <= '0;
        end
        else
        begin
            cmd_valid_o <= cmd_valid_i;
            if (cmd_valid_i)
                cmd_o <= pos_mode_i ? chain_out[CMD_W-1:0] : cmd_i;  // see RL1
        end
    end

    assign avs_waitrequest_o = wait_q;
    assign avs_readdata_o    = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    a_bypass_mode: assert property (@(posedge ref_clk_i) disable iff (reset_i)  // see RL1
        (cmd_valid_i && !pos_mode_i) |=> (cmd_valid_o && cmd_o == $past(cmd_i)))
        else $error("command not bypassed outside position mode");
    a_two_max: assert property (@(posedge ref_clk_i) disable iff (reset_i)  // see RL2
        $countones(en_mask) <= 2)
        else $error("more than two damping filters active");
    a_dir_pos: assert property (@(posedge ref_clk_i) disable iff (reset_i)  // see RL6
        (sel_act_q == CDF_SEL_DIR && !dir_neg) |-> ((en_mask & 4'hA) == 4'h0
        && en_mask[0] == valid_mask[0] && en_mask[2] == valid_mask[2]))
        else $error("wrong filters for positive direction");
    a_dir_neg: assert property (@(posedge ref_clk_i) disable iff (reset_i)  // see RL7
        (sel_act_q == CDF_SEL_DIR && dir_neg) |-> ((en_mask & 4'h5) == 4'h0
        && en_mask[1] == valid_mask[1] && en_mask[3] == valid_mask[3]))
        else $error("wrong filters for negative direction");
    a_freq_invalid: assert property (@(posedge ref_clk_i) disable iff (reset_i)  // see RL9
        (freq_act_q[0] <= CDF_FREQ_INVLD) |-> !en_mask[0])
        else $error("invalid frequency left filter enabled");
    a_filt_clamp: assert property (@(posedge ref_clk_i) disable iff (reset_i)  // see RL10
        apply |=> ({1'b0, filt_act_q[1]} <= freq_act_q[1]
        && {1'b0, filt_act_q[1]} <= CDF_FREQ_MAX - freq_act_q[1]))
        else $error("filter setting not clamped");
    a_apply_only: assert property (@(posedge ref_clk_i) disable iff (reset_i)  // see RL14
        (freq_act_q[0] != $past(freq_act_q[0])) |-> $past(switch_now && state_q == CDF_ST_PEND))
        else $error("settings applied outside a command start");
    a_calc_hold: assert property (@(posedge ref_clk_i) disable iff (reset_i)  // see RL15
        wr_ok |=> (state_q == CDF_ST_CALC && !apply) [*2])
        else $error("settings applied during computation delay");
    a_pass_thru: assert property (@(posedge ref_clk_i) disable iff (reset_i)  // see RL16
        (cmd_valid_i && pos_mode_i && en_mask == 4'h0) |=> (cmd_o == $past(cmd_i)))
        else $error("idle filter chain altered command");
    a_freq_range: assert property (@(posedge ref_clk_i) disable iff (reset_i)  // see RL8
        wr_ok && avs_address_i == CDF_OFS_FREQ0 |=> freq_sh_q[0] <= CDF_FREQ_MAX)
        else $error("frequency setting out of range");

endmodule // cdf_filter_select

`default_nettype wire

//--- include/cdf_pkg.sv
// Constants shared by the command damping filter selector
package cdf_pkg;

    // Register byte offsets (word aligned)
    localparam logic [5:0] CDF_OFS_SEL    = 6'h00;
    localparam logic [5:0] CDF_OFS_DEPTH  = 6'h04;
    localparam logic [5:0] CDF_OFS_FREQ0  = 6'h08;
    localparam logic [5:0] CDF_OFS_FILT0  = 6'h18;
    localparam logic [5:0] CDF_OFS_STATUS = 6'h28;

    // Field widths and positions
    localparam int CDF_FREQ_W  = 11;
    localparam int CDF_FILT_W  = 10;
    localparam int CDF_SEL_W   = 2;
    localparam int CDF_NFILT   = 4;
    localparam int CDF_ST_EN   = 4;
    localparam int CDF_ST_DIR  = 8;
    localparam int CDF_ST_FSM  = 12;

    // Setting limits and codes, 0.1 Hz units
    localparam logic [10:0] CDF_FREQ_MAX    = 11'h7D0;
    localparam logic [10:0] CDF_FREQ_INVLD  = 11'h009;
    localparam logic [9:0]  CDF_FILT_MAX    = 10'h3E8;
    localparam logic [9:0]  CDF_DEPTH_MAX   = 10'h3E8;
    localparam logic [1:0]  CDF_SEL_SIMUL   = 2'h0;
    localparam logic [1:0]  CDF_SEL_DIR     = 2'h3;

    // Reset values
    localparam logic [10:0] CDF_FREQ_RST  = 11'h000;
    localparam logic [9:0]  CDF_FILT_RST  = 10'h000;
    localparam logic [9:0]  CDF_DEPTH_RST = 10'h000;
    localparam logic [1:0]  CDF_SEL_RST   = 2'h0;

    // Filter arithmetic scaling
    localparam int CDF_COEF_SHIFT  = 12;
    localparam int CDF_DEPTH_SHIFT = 10;

    // Settings computation delay
    localparam int CDF_CLK_PERIOD_NS = 4;
    localparam int CDF_CALC_TIME_NS  = 200;
    localparam int CDF_CALC_CYC = (CDF_CALC_TIME_NS + CDF_CLK_PERIOD_NS - 1) / CDF_CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        CDF_ST_IDLE = 3'b001,
        CDF_ST_CALC = 3'b010,
        CDF_ST_PEND = 3'b100
    } cdf_state_t;

endpackage

//--- verification/cdf_cmd_model.sv
// Position command source model feeding the damping filter selector
`timescale 1ns/100ps
`default_nettype none

module cdf_cmd_model (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        send_i,
    input  wire logic [15:0] val_i,
    input  wire logic [3:0]  gap_i,
    output logic             busy_o,
    output logic             cmd_valid_o,
    output logic      [15:0] cmd_o
);

    ////////////////////////////////////////////////////////////////////////////
    logic [3:0]  cnt_q;
    logic [15:0] hold_q;
    logic [15:0] last_q;

    // Gap lets the source answer promptly or slowly
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            busy_o      <= 1'b0;
            cnt_q       <= 4'h0;
            hold_q      <= 16'h0000;
            last_q      <= 16'h0000;
            cmd_valid_o <= 1'b0;
            cmd_o       <= 16'h0000;
        end
        else
        begin
            cmd_valid_o <= 1'b0;
            // Data outside a pulse is junk, never the last value
            cmd_o       <= ~last_q;
            if (send_i && !busy_o)
            begin
                busy_o <= 1'b1;
                cnt_q  <= gap_i;
                hold_q <= val_i;
            end
            else if (busy_o && cnt_q == 4'h0)
            begin
                busy_o      <= 1'b0;
                cmd_valid_o <= 1'b1;
                cmd_o       <= hold_q;
                last_q      <= hold_q;
            end
            else if (busy_o)
                cnt_q <= cnt_q - 4'h1;
        end
    end

endmodule // cdf_cmd_model

`default_nettype wire

//--- verification/tb_top.sv
// Self-checking testbench for the command damping filter selector
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import cdf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    logic        ref_clk_i = 1'b0;
    logic        reset_i   = 1'b1;
    logic [5:0]  addr      = 6'h00;
    logic        rd_en     = 1'b0;
    logic        wr_en     = 1'b0;
    logic [31:0] wdata     = 32'h0;
    logic        pos_mode  = 1'b0;
    logic        inpos     = 1'b0;
    logic        snd_req   = 1'b0;
    logic [15:0] snd_val   = 16'h0;
    logic [3:0]  snd_gap   = 4'h0;
    logic        chk_rd    = 1'b0;
    logic [31:0] rdata;
    logic        wait_req;
    logic        busy;
    logic        vin;
    logic        vout;
    logic [15:0] cin;
    logic [15:0] cout;
    logic [31:0] rq[$];
    logic [15:0] cq_val[$];
    logic [1:0]  cq_mode[$];
    int          seed      = 32'h9452;
    int          error_cnt = 0;
    int          n_checks  = 0;

    always #2 ref_clk_i = ~ref_clk_i;

    cdf_filter_select i_cdf_filter_select (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .avs_address_i(addr),
        .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req), .pos_mode_i(pos_mode),
        .inpos_i(inpos), .cmd_valid_i(vin), .cmd_i(cin), .cmd_valid_o(vout), .cmd_o(cout));

    cdf_cmd_model i_cdf_cmd_model (
        .clk_i(ref_clk_i), .reset_i(reset_i), .send_i(snd_req), .val_i(snd_val),
        .gap_i(snd_gap), .busy_o(busy), .cmd_valid_o(vin), .cmd_o(cin));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic timeout(input string nm);
        error_cnt++;
        $display("unexpected timeout waiting for %s", nm);
        end_sim();
    endtask

    // Request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        wr_en <= w;
        rd_en <= !w;
        addr  <= a;
        wdata <= d;
        do
        begin
            @(posedge ref_clk_i);
            n++;
        end while (wait_req !== 1'b0 && n < 20);
        q = rdata;
        if (wait_req !== 1'b0)
            timeout("bus");
        wr_en <= 1'b0;
        rd_en <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] q;
        rq.push_back(exp);
        chk_rd <= 1'b1;
        bus(1'b0, a, 32'h0, q);
        chk_rd <= 1'b0;
    endtask

    // Mode 0 equal, 1 must differ, 2 not judged
    task automatic snd(input logic [15:0] v, input logic [1:0] m);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        while (busy && n < 50)
        begin
            @(posedge ref_clk_i);
            n++;
        end
        if (busy)
            timeout("command source");
        cq_val.push_back(v);
        cq_mode.push_back(m);
        snd_req <= 1'b1;
        snd_val <= v;
        snd_gap <= {1'b0, 3'($random(seed))};
        @(posedge ref_clk_i);
        snd_req <= 1'b0;
        // Return only once the pulse has reached the block
        n = 0;
        do
        begin
            @(posedge ref_clk_i);
            n++;
        end while (busy !== 1'b0 && n < 50);
        if (busy !== 1'b0)
            timeout("command pulse");
    endtask

    task automatic wait_pend();
        int n;
        logic [31:0] q;
        n = 0;
        q = 32'h0;
        while (q[CDF_ST_FSM +: 3] !== 3'b100 && n < 40)
        begin
            bus(1'b0, CDF_OFS_STATUS, 32'h0, q);
            n++;
        end
        if (q[CDF_ST_FSM +: 3] !== 3'b100)
            timeout("settings pending");
    endtask

    function automatic logic [31:0] stat(input logic [1:0] s, input logic [3:0] m,
                                          input logic dn, input logic [2:0] f);
        return {17'h0, f, 3'h0, dn, m, 2'h0, s};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Scoreboard: oldest note against each result
    always @(posedge ref_clk_i)
    begin
        if (rd_en && wait_req === 1'b0 && chk_rd && rq.size() > 0)
            chk("readdata", rdata, rq.pop_front());
        if (vout === 1'b1 && cq_val.size() > 0)
        begin
            if (cq_mode[0] == 2'd0)
                chk("cmd_o", {16'h0, cout}, {16'h0, cq_val[0]});
            else if (cq_mode[0] == 2'd1)
                chk("cmd_o filtered", {31'h0, cout !== cq_val[0]}, 32'h1);
            void'(cq_val.pop_front());
            void'(cq_mode.pop_front());
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (10) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        rd_chk(CDF_OFS_SEL, 32'h0);
        rd_chk(CDF_OFS_FREQ0, 32'h0);
        rd_chk(CDF_OFS_STATUS, stat(2'h0, 4'h0, 1'b0, 3'b001));
        rd_chk(6'h2C, 32'h0);
        rd_chk(6'h09, 32'h0);
        wr(CDF_OFS_FREQ0, 32'hFFFF);
        rd_chk(CDF_OFS_FREQ0, {21'h0, CDF_FREQ_MAX});
        wr(CDF_OFS_FILT0, 32'hFFFF);
        rd_chk(CDF_OFS_FILT0, {22'h0, CDF_FILT_MAX});
        wr(CDF_OFS_DEPTH, 32'hFFFF);
        rd_chk(CDF_OFS_DEPTH, {22'h0, CDF_DEPTH_MAX});
        wr(CDF_OFS_DEPTH, 32'h0);
        wr(CDF_OFS_FILT0, 32'h0);
        // No active filter yet: command passes untouched
        pos_mode <= 1'b1;
        repeat (6) snd(16'($random(seed)), 2'd0);
        wr(CDF_OFS_FREQ0, 32'd100);
        wr(CDF_OFS_FREQ0 + 6'h04, 32'd9);
        wr(CDF_OFS_FREQ0 + 6'h08, 32'd50);
        wr(CDF_OFS_FREQ0 + 6'h0C, 32'd2000);
        wait_pend();
        inpos <= 1'b1;
        snd(16'h0000, 2'd0);
        snd(16'd100, 2'd2);
        rd_chk(CDF_OFS_STATUS, stat(2'h0, 4'b0101, 1'b0, 3'b001));
        snd(16'd1000, 2'd1);
        pos_mode <= 1'b0;
        repeat (6) snd(16'($random(seed)), 2'd0);
        // Start inside the computation delay is dropped
        pos_mode <= 1'b1;
        wr(CDF_OFS_FREQ0 + 6'h04, 32'd300);
        wr(CDF_OFS_FILT0 + 6'h04, 32'd1000);
        snd(16'h0000, 2'd2);
        snd(16'd50, 2'd2);
        rd_chk(CDF_OFS_STATUS, stat(2'h0, 4'b0101, 1'b0, 3'b010));
        wait_pend();
        snd(16'h0000, 2'd2);
        snd(16'd50, 2'd2);
        rd_chk(CDF_OFS_STATUS, stat(2'h0, 4'b0011, 1'b0, 3'b001));
        // Direction select; reserved codes never written
        wr(CDF_OFS_SEL, {30'h0, CDF_SEL_DIR});
        wait_pend();
        snd(16'h0000, 2'd2);
        snd(16'd200, 2'd2);
        rd_chk(CDF_OFS_STATUS, stat(2'h3, 4'b0101, 1'b0, 3'b001));
        snd(16'hFC18, 2'd2);
        rd_chk(CDF_OFS_STATUS, stat(2'h3, 4'b1010, 1'b1, 3'b001));
        repeat (30) @(posedge ref_clk_i);
        chk("left notes", cq_val.size() + rq.size(), 32'h0);
        end_sim();
    end

endmodule // tb_top

`default_nettype wire
